//--- jki_pkg.sv
// Package for the jog key increment control: register map, field
// positions, reset values, step sizes and the shared types.
// Assumes one clock domain and a plain address/strobe register port.
package jki_pkg;

  // Register offsets (byte addresses on the plain port)
  localparam logic [7:0] JKI_ADDR_KEYS = 8'h00;
  localparam logic [7:0] JKI_ADDR_SEL = 8'h04;
  localparam logic [7:0] JKI_ADDR_MODE = 8'h08;
  localparam logic [7:0] JKI_ADDR_STATUS = 8'h0C;
  localparam logic [7:0] JKI_ADDR_ALARM = 8'h10;
  localparam logic [7:0] JKI_ADDR_REMAIN = 8'h14;

  // Key register fields
  localparam int JKI_KEY_BLOCK_BIT = 0;
  localparam int JKI_KEY_MINUS_BIT = 6;
  localparam int JKI_KEY_PLUS_BIT = 7;

  // Step selection fields, same layout in request and status registers
  localparam int JKI_SEL_ONE_BIT = 0;
  localparam int JKI_SEL_TEN_BIT = 1;
  localparam int JKI_SEL_HUNDRED_BIT = 2;
  localparam int JKI_SEL_THOUSAND_BIT = 3;
  localparam int JKI_SEL_CONT_BIT = 6;

  // Mode register fields
  localparam int JKI_MODE_LSB = 0;
  localparam int JKI_CHAN_BUSY_BIT = 4;

  // Status register extra fields
  localparam int JKI_STAT_PENDING_BIT = 8;
  localparam int JKI_STAT_MOVING_BIT = 9;
  localparam int JKI_STAT_DIR_BIT = 10;

  // Reset values
  localparam logic [4:0] JKI_SEL_RESET = 5'h00;
  localparam logic [1:0] JKI_MODE_RESET = 2'h0;

  // Alarm code reported when the channel already moves the axis
  localparam logic [15:0] JKI_ALARM_CHAN_BUSY = 16'h4E5E;

  // Step sizes in increments
  localparam logic [9:0] JKI_STEP_ONE = 10'h001;
  localparam logic [9:0] JKI_STEP_TEN = 10'h00A;
  localparam logic [9:0] JKI_STEP_HUNDRED = 10'h064;
  localparam logic [9:0] JKI_STEP_THOUSAND = 10'h3E8;

  typedef enum logic [1:0]
  {
    JKI_MODE_JOG = 2'h0,
    JKI_MODE_AUTO = 2'h1,
    JKI_MODE_MDI = 2'h2
  } jki_mode_t;

  typedef struct packed
  {
    logic plus;
    logic minus;
    logic block;
  } jki_keys_t;

  // Internal selection: {cont, thousand, hundred, ten, one}
  typedef logic [4:0] jki_sel_t;

endpackage

//--- jki_step_cnt.sv
// Remaining-increment counter for one axis step.
// Assumes load, decrement and clear are exclusive in the caller's use;
// clear wins, then load, then decrement.
`timescale 1ns/1ps
`default_nettype none
module jki_step_cnt
  import jki_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Control
  input wire logic load_i,
  input wire logic [9:0] load_val_i,
  input wire logic dec_i,
  input wire logic clear_i,
  // State
  output logic [9:0] remain_o,
  output logic last_o
);

  logic [9:0] next_remain;

  assign next_remain = clear_i ? 10'h000 :
                       load_i ? load_val_i :
                       (dec_i && remain_o != 10'h000) ?
                       10'(remain_o - 10'h001) : remain_o;

  assign last_o = (remain_o == 10'h001);

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      remain_o <= 10'h000;
    else
      remain_o <= next_remain;
  end

endmodule
`default_nettype wire

//--- jki_jog_ctrl.sv
// Jog key increment control for one machine axis: traversing keys,
// step-size selection, halt/resume of unfinished steps, alarm on refusal.
// Assumes the controller writes the interface bits through the register
// port each cycle it changes them; one increment is commanded per clock.
`timescale 1ns/1ps
`default_nettype none
module jki_jog_ctrl
  import jki_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rd_data_o,
  // Axis motion
  output logic step_o,
  output logic dir_minus_o,
  // Status toward the controller
  output logic [4:0] active_sel_o,
  output logic alarm_o
);

  typedef enum logic [1:0] {S_IDLE, S_INCR, S_HOLD, S_CONT} jki_state_t;

  function automatic logic [9:0] step_len(input jki_sel_t sel);
    step_len = sel[3] ? JKI_STEP_THOUSAND :
               sel[2] ? JKI_STEP_HUNDRED :
               sel[1] ? JKI_STEP_TEN :
               sel[0] ? JKI_STEP_ONE : 10'h000;
  endfunction

  function automatic logic is_single(input jki_sel_t sel);
    is_single = (sel != 5'h00) && ((sel & 5'(sel - 5'h01)) == 5'h00);
  endfunction

  // Interface registers
  jki_keys_t keys;
  jki_sel_t req_sel;
  jki_mode_t mode;
  logic chan_busy;
  // Internal state
  jki_state_t state;
  jki_state_t next_state;
  logic prev_want;
  logic [9:0] remain;
  logic rem_last;

  // Decode
  wire is_jog = (mode == JKI_MODE_JOG);
  wire keys_live = is_jog && !keys.block;
  wire want_plus = keys_live && keys.plus && !keys.minus;
  wire want_minus = keys_live && keys.minus && !keys.plus;
  wire want_any = want_plus || want_minus;
  wire press = want_any && !prev_want;
  wire held_dir_key = dir_minus_o ? want_minus : want_plus;
  wire sel_single = is_single(req_sel);
  // Outside jog the selection is frozen
  wire [4:0] next_active = is_jog ? (sel_single ? req_sel : 5'h00) :
                           active_sel_o;
  wire sel_changed = (next_active != active_sel_o);
  wire incr_active = |active_sel_o[3:0];
  // No request bit at all means continuous; a conflict means no motion
  wire cont_mode = active_sel_o[4] || (req_sel == 5'h00);
  wire moving_state = (state == S_INCR) || (state == S_CONT);
  wire step_now = moving_state && held_dir_key && !chan_busy &&
                  !sel_changed;
  wire start_ok = (state == S_IDLE) && press && !chan_busy;
  wire load_step = start_ok && incr_active;
  wire abort = (state == S_INCR || state == S_HOLD) && sel_changed;
  wire alarm_set = press && chan_busy;
  wire alarm_clr = wr_i && (addr_i == JKI_ADDR_ALARM);
  wire [15:0] status_word = {5'h00, dir_minus_o,
                             (state == S_INCR || state == S_CONT),
                             (state == S_INCR || state == S_HOLD),
                             1'b0, active_sel_o[4], 2'h0,
                             active_sel_o[3:0]};
  wire [15:0] rd_mux =
    (addr_i == JKI_ADDR_KEYS) ? {8'h00, keys.plus, keys.minus, 5'h00,
                                 keys.block} :
    (addr_i == JKI_ADDR_SEL) ? {9'h000, req_sel[4], 2'h0, req_sel[3:0]} :
    (addr_i == JKI_ADDR_MODE) ? {11'h000, chan_busy, 2'h0, mode} :
    (addr_i == JKI_ADDR_STATUS) ? status_word :
    (addr_i == JKI_ADDR_ALARM) ? (alarm_o ? JKI_ALARM_CHAN_BUSY : 16'h0000) :
    (addr_i == JKI_ADDR_REMAIN) ? {6'h00, remain} : 16'h0000;

  jki_step_cnt u_cnt
  (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .load_i(load_step),
    .load_val_i(step_len(active_sel_o)),
    .dec_i(step_now && state == S_INCR),
    .clear_i(abort),
    .remain_o(remain),
    .last_o(rem_last)
  );

  always_comb
  begin
    next_state = state;
    unique case (state)
      S_IDLE:
        if (start_ok && incr_active)
          next_state = S_INCR;
        else if (start_ok && cont_mode)
          next_state = S_CONT;
      S_INCR:
        if (sel_changed)
          next_state = S_IDLE;
        else if (step_now && rem_last)
          next_state = S_IDLE;
        else if (!step_now)
          next_state = S_HOLD;
      S_HOLD:
        if (sel_changed)
          next_state = S_IDLE;
        else if (held_dir_key && !chan_busy)
          next_state = S_INCR;
      S_CONT:
        if (!step_now || !cont_mode)
          next_state = S_IDLE;
    endcase
  end

  // Interface bits written by the controller
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      keys <= '0;
      req_sel <= JKI_SEL_RESET;
      mode <= jki_mode_t'(JKI_MODE_RESET);
      chan_busy <= 1'b0;
    end
    else if (wr_i)
    begin
      if (addr_i == JKI_ADDR_KEYS)
        keys <= {wr_data_i[JKI_KEY_PLUS_BIT], wr_data_i[JKI_KEY_MINUS_BIT],
                 wr_data_i[JKI_KEY_BLOCK_BIT]};
      if (addr_i == JKI_ADDR_SEL)
        req_sel <= {wr_data_i[JKI_SEL_CONT_BIT],
                    wr_data_i[JKI_SEL_THOUSAND_BIT:JKI_SEL_ONE_BIT]};
      if (addr_i == JKI_ADDR_MODE)
      begin
        mode <= jki_mode_t'(wr_data_i[JKI_MODE_LSB +: 2]);
        chan_busy <= wr_data_i[JKI_CHAN_BUSY_BIT];
      end
    end
  end

  // Read data stands for the single cycle after the strobe
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      rd_data_o <= 16'h0000;
    else
      rd_data_o <= rd_i ? rd_mux : 16'h0000;
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state <= S_IDLE;
      prev_want <= 1'b0;
      step_o <= 1'b0;
      dir_minus_o <= 1'b0;
      active_sel_o <= 5'h00;
      alarm_o <= 1'b0;
    end
    else
    begin
      state <= next_state;
      prev_want <= want_any;
      step_o <= step_now;
      if (start_ok)
        dir_minus_o <= want_minus;
      active_sel_o <= next_active;
      // A new refusal in the clearing cycle wins over the clear
      alarm_o <= alarm_set || (alarm_o && !alarm_clr);
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  step_direction_a: assert property (
    step_o |-> (dir_minus_o ? $past(want_minus) : $past(want_plus)))
    else $error("step issued without matching key");

  step_start_a: assert property (
    (state == S_IDLE && press && !chan_busy && incr_active &&
     !sel_changed) ##1 (held_dir_key && !chan_busy && !sel_changed)
    |=> step_o && state != S_HOLD)
    else $error("step did not start on key press");

  halt_keeps_rest_a: assert property (
    (state == S_INCR && !held_dir_key && !sel_changed && remain != 10'h000)
    |=> state == S_HOLD && $stable(remain))
    else $error("halt lost the remaining step");

  resume_step_a: assert property (
    (state == S_HOLD && held_dir_key && !chan_busy && !sel_changed)
    |=> state == S_INCR && $stable(remain))
    else $error("resume did not continue the step");

  // The key may drop again right after the resume, so only a kept key
  // obliges the next increment
  resume_pulse_a: assert property (
    (state == S_HOLD && held_dir_key && !chan_busy && !sel_changed)
    ##1 (held_dir_key && !chan_busy && !sel_changed) |=> step_o)
    else $error("resumed step gave no increment");

  hold_repeat_a: assert property (
    (state == S_HOLD && !sel_changed && !(held_dir_key && !chan_busy))
    |=> state == S_HOLD && remain == $past(remain))
    else $error("pending step dropped while halted");

  cont_move_a: assert property (
    (state == S_CONT && held_dir_key && !chan_busy && !sel_changed)
    |=> step_o)
    else $error("continuous motion stopped while key held");

  key_block_a: assert property (
    keys.block |=> !step_o)
    else $error("blocked keys produced motion");

  mode_ignore_a: assert property (
    !is_jog |=> !step_o)
    else $error("keys acted outside jog mode");

  chan_refuse_a: assert property (
    (press && chan_busy) |=> alarm_o && !step_o)
    else $error("channel-driven axis not refused");

  sel_report_a: assert property (
    (is_jog && sel_single) |=> active_sel_o == $past(req_sel))
    else $error("active selection not reported");

  sel_conflict_a: assert property (
    (is_jog && !sel_single) |=> active_sel_o == 5'h00)
    else $error("conflicting selection activated");

  sel_frozen_a: assert property (
    !is_jog |=> $stable(active_sel_o))
    else $error("selection changed outside jog");

  sel_abort_a: assert property (
    ((state == S_INCR || state == S_HOLD) && sel_changed)
    |=> state == S_IDLE && remain == 10'h000)
    else $error("selection change did not abort step");

  both_keys_a: assert property (
    (keys.plus && keys.minus) |=> !step_o)
    else $error("both keys produced motion");

  cont_stop_a: assert property (
    (state == S_CONT && !held_dir_key) |=> !step_o && state == S_IDLE)
    else $error("continuous motion ran on after key drop");

  step_count_a: assert property (
    (state == S_INCR && step_now)
    |=> remain == 10'($past(remain) - 10'h001))
    else $error("increment count slipped");

  alarm_hold_a: assert property (
    (alarm_o && !alarm_clr) |=> alarm_o)
    else $error("alarm dropped without a clear");

  alarm_clear_a: assert property (
    (alarm_clr && !alarm_set) |=> !alarm_o)
    else $error("alarm survived its clear");

  step_done_c: cover property (
    state == S_INCR && step_now && rem_last);
  halt_resume_c: cover property (
    state == S_HOLD ##1 state == S_INCR);
  cont_run_c: cover property (
    state == S_CONT && step_o);
  refuse_c: cover property (
    alarm_set);

endmodule
`default_nettype wire

//--- jki_plc_model.sv
// Controller-side model: a PLC program writing the jog interface bits.
// Assumes the bench launches its requests just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module jki_plc_model
  import jki_pkg::*;
(
  // Requests of the PLC program
  input wire logic [7:0] req_addr_i,
  input wire logic [15:0] req_data_i,
  input wire logic req_wr_i,
  input wire logic req_rd_i,
  // Register port, master side
  output logic [7:0] addr_o,
  output logic [15:0] wr_data_o,
  output logic wr_o,
  output logic rd_o
);
  wire bus_busy = req_wr_i || req_rd_i;

  // Released bus shows inverted garbage, never a stale copy
  assign addr_o = bus_busy ? req_addr_i : ~req_addr_i;
  assign wr_data_o = req_wr_i ? req_data_i : ~req_data_i;
  assign wr_o = req_wr_i;
  assign rd_o = req_rd_i;
endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the jog control, driven by the PLC model.
// Assumes the register map and latencies of the package and hand-over.
`timescale 1ns/1ps
`default_nettype none
`define JKI_CHK(got, exp) compare(16'(got), 16'(exp))
module tb_top
  import jki_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] bus_addr;
  logic [15:0] bus_wdata;
  logic bus_wr;
  logic bus_rd;
  logic [7:0] req_addr = 8'h00;
  logic [15:0] req_data = 16'h0000;
  logic req_wr = 1'b0;
  logic req_rd = 1'b0;
  logic [15:0] rd_data;
  logic step;
  logic dir_minus;
  logic [4:0] active_sel;
  logic alarm;
  logic rd_seen = 1'b0;
  logic [15:0] exp_q[$];
  int mismatches = 0;
  int check_count = 0;
  int pulses = 0;
  int base = 0;
  int seed = 25756;
  int k;
  logic [15:0] mode_tab [4] = '{16'h0000, 16'h0001, 16'h0002, 16'h0000};
  logic [15:0] key_tab [4] = '{16'h0081, 16'h0080, 16'h0080, 16'h00C0};

  always #5 ref_clk_i = ~ref_clk_i;

  jki_plc_model plc (.req_addr_i(req_addr), .req_data_i(req_data),
    .req_wr_i(req_wr), .req_rd_i(req_rd), .addr_o(bus_addr),
    .wr_data_o(bus_wdata), .wr_o(bus_wr), .rd_o(bus_rd));

  jki_jog_ctrl dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .addr_i(bus_addr), .wr_data_i(bus_wdata), .wr_i(bus_wr),
    .rd_i(bus_rd), .rd_data_o(rd_data), .step_o(step),
    .dir_minus_o(dir_minus), .active_sel_o(active_sel), .alarm_o(alarm));

  task automatic compare(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // One-cycle strobes, launched just after an edge
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    req_addr <= a;
    req_data <= d;
    req_wr <= 1'b1;
    @(posedge ref_clk_i);
    req_wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge ref_clk_i);
    req_addr <= a;
    req_rd <= 1'b1;
    @(posedge ref_clk_i);
    req_rd <= 1'b0;
  endtask

  // Five separate request bits, continuous sits apart from the steps
  task automatic select_step(input jki_sel_t s);
    wr_reg(JKI_ADDR_SEL, {9'h000, s[4], 2'h0, s[3:0]});
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    exp_q.push_back(exp);
    rd_reg(a);
  endtask

  task automatic keys(input logic [15:0] kv);
    wr_reg(JKI_ADDR_KEYS, kv);
  endtask

  // Bounded wait for the increment count to reach n
  task automatic wait_pulses(input int n);
    int i;
    for (i = 0; i < 3000 && pulses < n; i++)
      @(posedge ref_clk_i);
    if (pulses < n)
    begin
      mismatches++;
      stop_test();
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge ref_clk_i)
  begin
    if (step === 1'b1)
      pulses++;
    if (rd_seen === 1'b1)
      `JKI_CHK(rd_data, exp_q.pop_front());
    rd_seen <= bus_rd;
  end

  initial
  begin
    idle(5);
    sys_rst_i <= 1'b0;
    rd(JKI_ADDR_STATUS, 16'h0000);
    rd(JKI_ADDR_ALARM, 16'h0000);
    wr_reg(8'h18, 16'($random(seed)));
    rd(8'h18, 16'h0000);
    select_step(5'h02);
    rd(JKI_ADDR_STATUS, 16'h0002);
    keys(16'h0080);
    wait_pulses(10);
    idle(6);
    `JKI_CHK(pulses, 10);
    `JKI_CHK(dir_minus, 0);
    rd(JKI_ADDR_REMAIN, 16'h0000);
    keys(16'h0000);
    // Hundred, minus, halted three times at random lengths
    select_step(5'h04);
    base = pulses;
    for (k = 0; k < 3; k++)
    begin
      keys(16'h0040);
      wait_pulses(base + 20 * (k + 1));
      keys(16'h0000);
      idle(3 + ($unsigned($random(seed)) % 4));
      rd(JKI_ADDR_REMAIN, 16'(100 - (pulses - base)));
    end
    keys(16'h0040);
    wait_pulses(base + 100);
    idle(6);
    `JKI_CHK(pulses - base, 100);
    `JKI_CHK(dir_minus, 1);
    keys(16'h0000);
    select_step(5'h10);
    rd(JKI_ADDR_STATUS, 16'h0440);
    keys(16'h0080);
    idle(20);
    `JKI_CHK(step, 1);
    keys(16'h0000);
    idle(4);
    base = pulses;
    idle(10);
    `JKI_CHK(pulses - base, 0);
    // Selection change in mid step aborts it
    select_step(5'h08);
    keys(16'h0080);
    wait_pulses(base + 20);
    select_step(5'h01);
    idle(4);
    base = pulses;
    idle(10);
    `JKI_CHK(pulses - base, 0);
    `JKI_CHK(active_sel, 5'h01);
    rd(JKI_ADDR_REMAIN, 16'h0000);
    keys(16'h0000);
    for (k = 0; k < 4; k++)
    begin
      wr_reg(JKI_ADDR_MODE, mode_tab[k]);
      keys(key_tab[k]);
      idle(10);
      `JKI_CHK(pulses - base, 0);
      keys(16'h0000);
    end
    wr_reg(JKI_ADDR_MODE, 16'h0001);
    select_step(5'h04);
    idle(2);
    `JKI_CHK(active_sel, 5'h01);
    wr_reg(JKI_ADDR_MODE, 16'h0000);
    idle(2);
    `JKI_CHK(active_sel, 5'h04);
    select_step(5'h03);
    keys(16'h0080);
    idle(10);
    `JKI_CHK(active_sel, 5'h00);
    `JKI_CHK(pulses - base, 0);
    keys(16'h0000);
    // Axis already driven by the channel: refuse and raise the alarm
    wr_reg(JKI_ADDR_MODE, 16'h0010);
    select_step(5'h01);
    keys(16'h0080);
    idle(10);
    `JKI_CHK(alarm, 1);
    `JKI_CHK(pulses - base, 0);
    rd(JKI_ADDR_ALARM, 16'h4E5E);
    keys(16'h0000);
    wr_reg(JKI_ADDR_ALARM, 16'h0000);
    rd(JKI_ADDR_ALARM, 16'h0000);
    idle(4);
    stop_test();
  end
endmodule
`default_nettype wire
